// [src/usb_device_irq_status.sv]
`timescale 1ns/100ps
`default_nettype none
`include "usb_irq_defines.svh"

module usb_device_irq_status
  import usb_irq_pkg::*;
#(
  parameter int unsigned ADDR_W = 8,
  parameter int unsigned EP_NUM = 6,
  parameter int unsigned SUSPEND_CYCLES = `SUSPEND_TIME_US * `CLK_FREQ_MHZ,
  parameter int unsigned RESUME_DRIVE_CYCLES = `RESUME_DRIVE_TIME_US * `CLK_FREQ_MHZ
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Endpoint status flags, one bit per endpoint
  input wire logic [EP_NUM-1:0] setup_received,
  input wire logic [EP_NUM-1:0] bank0_received,
  input wire logic [EP_NUM-1:0] bank1_received,
  input wire logic [EP_NUM-1:0] in_transfer_done,
  input wire logic [EP_NUM-1:0] stall_acknowledged,
  // Bus event strobes from the serial engine
  input wire logic bus_activity,
  input wire logic host_resume_seen,
  input wire logic frame_start_seen,
  input wire logic bus_reset_seen,
  input wire logic bus_reset_done,
  // Asynchronous remote wake request
  input wire logic remote_wake_request,
  // Outputs
  output logic irq,
  output logic suspended,
  output logic send_k_state
);

  // Suspend and resume drive state
  link_state_t state_reg;
  // Shared idle / drive counter
  logic [31:0] cnt_reg;
  // Software registers
  logic [31:0] mask_reg;
  logic [31:0] status_reg;
  logic [31:0] ctrl_reg;
  logic [31:0] prdata_reg;
  logic irq_reg;
  // Wake request synchroniser and edge detect
  logic wake_sync1_reg;
  logic wake_sync2_reg;
  logic wake_sync3_reg;
  logic wake_rise;
  // Decoded bus strobes
  logic setup_phase;
  logic access;
  logic wr_access;
  logic rd_status;
  logic addr_ok;
  // Combined views
  logic [EP_NUM-1:0] endpoint_event;
  logic [31:0] pending_view;
  logic [31:0] read_mux;
  logic [31:0] event_set;
  logic [31:0] event_clr;
  logic suspend_event;
  logic external_resume_event;
  logic remote_wake_enable;
  logic resume_send_enable;
  logic idle_expired;
  logic drive_done;

  // Bus phases
  assign setup_phase = psel && !penable;
  assign access = psel && penable;
  assign wr_access = access && pwrite;
  assign rd_status = access && !pwrite && (paddr == `OFS_STATUS);

  // Zero wait states; unmapped addresses answer with an error
  assign pready = 1'b1;
  assign pslverr = access && !addr_ok;

  // Address decode
  always_comb begin
    unique case (paddr)
      `OFS_CTRL, `OFS_ENABLE, `OFS_DISABLE, `OFS_MASK, `OFS_STATUS, `OFS_CLEAR: begin
        addr_ok = 1'b1;
      end
      default: begin
        addr_ok = 1'b0;
      end
    endcase
  end

  // Control bits
  assign remote_wake_enable = ctrl_reg[`CTRL_REMOTE_WAKE];
  assign resume_send_enable = ctrl_reg[`CTRL_RESUME_SEND];

  // Endpoint flag is the live OR of its causes, so it only drops when firmware clears them
  assign endpoint_event = setup_received | bank0_received | bank1_received |
                          in_transfer_done | stall_acknowledged;

  // Status view: endpoint levels low, sticky bus events high
  always_comb begin
    pending_view = status_reg & `BUS_EVENT_BITS;
    pending_view[`BIT_EP0 +: EP_NUM] = endpoint_event;
  end

  // Read mux; write-only registers read as zero
  always_comb begin
    unique case (paddr)
      `OFS_CTRL: begin
        read_mux = ctrl_reg & `CTRL_VALID;
      end
      `OFS_MASK: begin
        read_mux = mask_reg & `MASK_VALID;
      end
      `OFS_STATUS: begin
        read_mux = pending_view & `STATUS_VALID;
      end
      default: begin
        read_mux = `ZERO_WORD;
      end
    endcase
  end

  // Read data is captured in the setup cycle and held through the access
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_reg <= `ZERO_WORD;
    end else if (setup_phase && !pwrite) begin
      prdata_reg <= read_mux;
    end
  end
  assign prdata = prdata_reg;

  // Control register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_reg <= `CTRL_RESET;
    end else if (wr_access && paddr == `OFS_CTRL) begin
      ctrl_reg <= pwdata & `CTRL_VALID;
    end
  end

  // Mask: set by enable writes, cleared by disable writes, never written directly
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mask_reg <= `MASK_RESET;
    end else if (wr_access && paddr == `OFS_ENABLE) begin
      mask_reg <= mask_reg | (pwdata & `MASK_VALID);
    end else if (wr_access && paddr == `OFS_DISABLE) begin
      mask_reg <= mask_reg & ~(pwdata & `MASK_VALID);
    end
  end

  // Wake request: two flops, then a third for the edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wake_sync1_reg <= 1'b0;
      wake_sync2_reg <= 1'b0;
      wake_sync3_reg <= 1'b0;
    end else begin
      wake_sync1_reg <= remote_wake_request;
      wake_sync2_reg <= wake_sync1_reg;
      wake_sync3_reg <= wake_sync2_reg;
    end
  end
  assign wake_rise = wake_sync2_reg && !wake_sync3_reg;

  // Link state events
  assign idle_expired = (state_reg == st_active) && !bus_activity &&
                        (cnt_reg == SUSPEND_CYCLES - 1);
  assign drive_done = (state_reg == st_driving_k) && (cnt_reg == RESUME_DRIVE_CYCLES - 1);
  assign suspend_event = idle_expired;
  assign external_resume_event = (state_reg == st_suspended) && wake_rise;

  // Suspend detection and resume drive sequencing
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= st_active;
    end else begin
      unique case (state_reg)
        st_active: begin
          // No traffic for the full idle time
          if (idle_expired) begin
            state_reg <= st_suspended;
          end
        end
        st_suspended: begin
          // Wake needs both enables, else only the flag is raised
          if (external_resume_event && remote_wake_enable && resume_send_enable) begin
            state_reg <= st_driving_k;
          end else if (bus_activity || host_resume_seen || bus_reset_seen) begin
            state_reg <= st_active;
          end
        end
        st_driving_k: begin
          // Host takes over the resume after our K
          if (drive_done) begin
            state_reg <= st_active;
          end
        end
      endcase
    end
  end

  // Counter restarts on activity and on every state change
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_reg <= 32'h00000000;
    end else if (bus_activity || idle_expired || drive_done ||
                 state_reg == st_suspended) begin
      cnt_reg <= 32'h00000000;
    end else begin
      cnt_reg <= cnt_reg + 32'h00000001;
    end
  end

  assign suspended = (state_reg == st_suspended);
  assign send_k_state = (state_reg == st_driving_k);

  // Sticky bus event sources
  always_comb begin
    event_set = `ZERO_WORD;
    event_set[`BIT_SUSPEND] = suspend_event;
    event_set[`BIT_HOST_RESUME] = host_resume_seen;
    event_set[`BIT_EXT_RESUME] = external_resume_event;
    event_set[`BIT_FRAME_START] = frame_start_seen;
    event_set[`BIT_BUS_RESET_DONE] = bus_reset_done;
    event_set[`BIT_WAKEUP] = host_resume_seen || bus_reset_seen;
  end

  // Clears: ones written to the clear register, or the bits a status read returned.
  // Clearing only what was read keeps an event that lands mid-read.
  always_comb begin
    event_clr = `ZERO_WORD;
    if (wr_access && paddr == `OFS_CLEAR) begin
      event_clr = pwdata & `BUS_EVENT_BITS;
    end else if (rd_status) begin
      event_clr = prdata_reg & `BUS_EVENT_BITS;
    end
  end

  // Set wins over a clear in the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status_reg <= `ZERO_WORD;
    end else begin
      status_reg <= ((status_reg & ~event_clr) | event_set) & `BUS_EVENT_BITS;
    end
  end

  // Interrupt level, registered: one cycle behind the status view
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_reg <= 1'b0;
    end else begin
      irq_reg <= |(pending_view & mask_reg & `STATUS_VALID);
    end
  end
  assign irq = irq_reg;

  // Checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  AST_ENABLE_SETS: assert property (
    (wr_access && paddr == `OFS_ENABLE) |=>
      ((mask_reg & $past(pwdata) & `MASK_VALID) == ($past(pwdata) & `MASK_VALID)))
    else $error("enable write did not set mask bits");

  AST_DISABLE_WAKEUP: assert property (
    (wr_access && paddr == `OFS_DISABLE && pwdata[`BIT_WAKEUP]) |=> !mask_reg[`BIT_WAKEUP])
    else $error("wakeup mask not cleared by disable write");

  // Checks the read path, not only the combined view
  AST_EP_FLAG: assert property (
    (setup_phase && !pwrite && paddr == `OFS_STATUS && setup_received[0]) |=>
      prdata[`BIT_EP0])
    else $error("endpoint flag missing from status read");

  AST_SUSPEND: assert property (
    idle_expired |=> (status_reg[`BIT_SUSPEND] && suspended))
    else $error("idle timeout did not suspend");

  AST_HOST_RESUME: assert property (
    host_resume_seen |=> status_reg[`BIT_HOST_RESUME] && status_reg[`BIT_WAKEUP])
    else $error("host resume flag not set");

  AST_EXT_RESUME: assert property (
    (suspended && wake_rise) |=> status_reg[`BIT_EXT_RESUME])
    else $error("external resume flag not set");

  AST_K_DRIVE: assert property (
    (suspended && wake_rise && remote_wake_enable && resume_send_enable)
      |=> send_k_state [*2])
    else $error("resume signalling not driven");

  AST_NO_K_WITHOUT_ENABLE: assert property (
    $rose(send_k_state) |-> $past(remote_wake_enable && resume_send_enable))
    else $error("K state driven without both enables");

  AST_FRAME_START: assert property (
    frame_start_seen |=> status_reg[`BIT_FRAME_START])
    else $error("frame start flag not set");

  AST_RESET_DONE_CLEAR: assert property (
    (wr_access && paddr == `OFS_CLEAR && pwdata[`BIT_BUS_RESET_DONE] && !bus_reset_done)
      |=> !status_reg[`BIT_BUS_RESET_DONE])
    else $error("bus reset done flag not cleared");

  AST_IRQ: assert property (
    irq |-> $past(|(pending_view & mask_reg & `STATUS_VALID)))
    else $error("interrupt without masked-in pending bit");

  AST_IRQ_RAISE: assert property (
    (|(pending_view & mask_reg & `STATUS_VALID)) |=> irq)
    else $error("masked-in pending bit did not raise the interrupt");

  // A clear write with a zero in the frame start bit must leave that flag alone
  AST_CLEAR_ZERO_KEEPS: assert property (
    (wr_access && paddr == `OFS_CLEAR && !pwdata[`BIT_FRAME_START] &&
     status_reg[`BIT_FRAME_START]) |=> status_reg[`BIT_FRAME_START])
    else $error("frame start flag lost on a zero clear write");

  AST_RESET_DONE_SET: assert property (
    bus_reset_done |=> status_reg[`BIT_BUS_RESET_DONE])
    else $error("bus reset done flag not set");

  // Wakeup only goes away through a clear write or a status read
  AST_WAKEUP_STICKY: assert property (
    (status_reg[`BIT_WAKEUP] && !event_clr[`BIT_WAKEUP]) |=> status_reg[`BIT_WAKEUP])
    else $error("wakeup flag dropped without a clear");

  // External resume is ignored while the link is awake
  AST_EXT_ONLY_SUSPENDED: assert property (
    $rose(status_reg[`BIT_EXT_RESUME]) |-> $past(suspended))
    else $error("external resume flag set outside suspend");

  // Coverage of the main scenarios
  COV_SUSPEND_WAKE: cover property (suspended ##[1:1000] send_k_state);
  COV_IRQ_FRAME: cover property (frame_start_seen ##2 irq);
  COV_READ_CLEAR: cover property (rd_status && prdata_reg[`BIT_WAKEUP]);
  COV_EXT_FLAG_ONLY: cover property (external_resume_event && !resume_send_enable);

endmodule

`default_nettype wire

// [src/usb_irq_defines.svh]
`ifndef USB_IRQ_DEFINES_SVH
`define USB_IRQ_DEFINES_SVH

// Register byte offsets
`define OFS_CTRL 8'h00
`define OFS_ENABLE 8'h10
`define OFS_DISABLE 8'h14
`define OFS_MASK 8'h18
`define OFS_STATUS 8'h1C
`define OFS_CLEAR 8'h20

// Bit positions shared by mask and status; BIT_BUS_RESET_DONE is status only
`define BIT_EP0 0
`define BIT_SUSPEND 8
`define BIT_HOST_RESUME 9
`define BIT_EXT_RESUME 10
`define BIT_FRAME_START 11
`define BIT_BUS_RESET_DONE 12
`define BIT_WAKEUP 13

// Field layouts and reset values
`define MASK_VALID 32'h00002F3F
`define STATUS_VALID 32'h00003F3F
`define BUS_EVENT_BITS 32'h00003F00
`define MASK_RESET 32'h00000200
`define CTRL_VALID 32'h00000003
`define CTRL_RESET 32'h00000000
`define CTRL_REMOTE_WAKE 0
`define CTRL_RESUME_SEND 1
`define ZERO_WORD 32'h00000000

// Timing
`define CLK_FREQ_MHZ 10
`define SUSPEND_TIME_US 3000
`define RESUME_DRIVE_TIME_US 1000

`endif

// [src/usb_irq_pkg.sv]
package usb_irq_pkg;
  // Bus power state, one-hot
  typedef enum logic [2:0] {
    st_active = 3'b001,
    st_suspended = 3'b010,
    st_driving_k = 3'b100
  } link_state_t;
endpackage

// [tb/tb.sv]
`timescale 1ns/100ps
`default_nettype none
`include "usb_irq_defines.svh"

module tb;
  // Bench drive
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic alive = 1'b1, wake_req = 1'b0, last_err;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h00000000, prdata, rd, exp, seed = 32'h0000CCED;
  logic [5:0] ep_in [5] = '{default: 6'h00};
  logic pready, pslverr, irq, suspended, send_k_state;
  logic act, rsm, sof, rst, rst_done;
  // Model state and tallies
  int fail_count = 0, comparisons = 0;
  logic [31:0] mdl_mask = 32'h00000200;
  logic [31:0] ev [4] = '{32'h00000800, 32'h00002200, 32'h00002000, 32'h00001000};

  usb_device_irq_status #(.SUSPEND_CYCLES(20), .RESUME_DRIVE_CYCLES(8)) uut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .setup_received(ep_in[0]), .bank0_received(ep_in[1]), .bank1_received(ep_in[2]),
    .in_transfer_done(ep_in[3]), .stall_acknowledged(ep_in[4]), .bus_activity(act),
    .host_resume_seen(rsm), .frame_start_seen(sof), .bus_reset_seen(rst),
    .bus_reset_done(rst_done), .remote_wake_request(wake_req), .irq(irq),
    .suspended(suspended), .send_k_state(send_k_state));

  usb_host_model host (.pclk(pclk), .alive(alive), .bus_activity(act),
    .host_resume_seen(rsm), .frame_start_seen(sof), .bus_reset_seen(rst),
    .bus_reset_done(rst_done));

  // 100 ns clock
  initial begin
    forever #50 pclk = ~pclk;
  end

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic chk(input logic [31:0] seen, input logic [31:0] want);
    comparisons++;
    if (seen !== want) begin
      fail_count++;
      $display("unexpected at %0t: saw %h, wanted %h", $time, seen, want);
    end
  endtask

  // One APB transfer; waits for pready, samples at that edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r);
    @(posedge pclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata;
    last_err = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask

  task automatic stop_test;
    if (fail_count == 0 && comparisons > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // Hang guard
  initial begin
    repeat (3000) @(posedge pclk);
    fail_count++;
    stop_test;
  end

  initial begin
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, `OFS_MASK, 32'h00000000, rd); chk(rd, mdl_mask);
    apb(1'b1, `OFS_ENABLE, 32'hFFFFFFFF, rd); mdl_mask = 32'h00002F3F;
    apb(1'b1, `OFS_DISABLE, 32'h00002000, rd); mdl_mask &= ~32'h00002000;
    apb(1'b1, `OFS_MASK, 32'h00000000, rd);
    apb(1'b0, `OFS_MASK, 32'h00000000, rd); chk(rd, mdl_mask);
    // Every host event, flag and gated interrupt
    for (int k = 0; k < 4; k++) begin
      host.send(k);
      @(posedge pclk);
      #1 chk(irq, 32'((ev[k] & mdl_mask) != 0));
      apb(1'b0, `OFS_STATUS, 32'h00000000, rd); chk(rd, ev[k]);
    end
    // Clearing by ones only
    for (int c = 0; c < 2; c++) begin
      host.send(c ? 3 : 0);
      apb(1'b1, `OFS_CLEAR, c ? 32'h00001800 : 32'h00000000, rd);
      apb(1'b0, `OFS_STATUS, 32'h00000000, rd); chk(rd, c ? 32'h0 : 32'h800);
    end
    // Random endpoint causes, masked and unmasked
    for (int i = 0; i < 4; i++) begin
      seed = lfsr(seed);
      if (i == 2) begin
        apb(1'b1, `OFS_DISABLE, 32'h0000003F, rd); mdl_mask &= ~32'h0000003F;
      end
      exp = 32'h0;
      @(posedge pclk);
      for (int j = 0; j < 5; j++) begin
        ep_in[j] <= seed[j*6 +: 6];
        exp |= 32'(seed[j*6 +: 6]);
      end
      repeat (2) @(posedge pclk);
      apb(1'b0, `OFS_STATUS, 32'h00000000, rd); chk(rd, exp);
      apb(1'b0, `OFS_STATUS, 32'h00000000, rd); chk(rd, exp);
      repeat (2) @(posedge pclk);
      #1 chk(irq, 32'((exp & mdl_mask) != 0));
    end
    for (int j = 0; j < 5; j++) ep_in[j] <= 6'h00;
    apb(1'b0, 8'h40, 32'h00000000, rd);
    chk(rd, 32'h0);
    chk(last_err, 32'h1);
    // Idle bus into suspend, then remote wake
    alive <= 1'b0;
    repeat (15) @(posedge pclk);
    #1 chk(suspended, 32'h0);
    repeat (10) @(posedge pclk);
    #1 chk(suspended, 32'h1);
    apb(1'b0, `OFS_STATUS, 32'h00000000, rd); chk(rd, 32'h00000100);
    apb(1'b1, `OFS_CTRL, 32'h00000003, rd);
    wake_req <= 1'b1;
    repeat (6) @(posedge pclk);
    #1 chk(send_k_state, 32'h1);
    apb(1'b0, `OFS_STATUS, 32'h00000000, rd); chk(rd, 32'h00000400);
    repeat (10) @(posedge pclk);
    #1 chk(send_k_state, 32'h0);
    // Wake request with only remote wake set: flag, no K; host resume wakes it
    apb(1'b1, `OFS_CTRL, 32'h00000001, rd);
    wake_req <= 1'b0;
    repeat (25) @(posedge pclk);
    wake_req <= 1'b1;
    repeat (6) @(posedge pclk);
    #1 chk(send_k_state, 32'h0);
    chk(suspended, 32'h1);
    host.send(1);
    @(posedge pclk);
    #1 chk(suspended, 32'h0);
    chk(irq, 32'h1);
    apb(1'b0, `OFS_STATUS, 32'h00000000, rd);
    chk(rd, 32'h00002700);
    stop_test;
  end
endmodule

`default_nettype wire

// [tb/usb_host_model.sv]
`timescale 1ns/100ps
`default_nettype none

module usb_host_model (
  // Clock
  input wire logic pclk,
  // Keep the bus busy
  input wire logic alive,
  // Line events as seen by the serial engine
  output logic bus_activity,
  output logic host_resume_seen,
  output logic frame_start_seen,
  output logic bus_reset_seen,
  output logic bus_reset_done
);
  // Quiet bus until told otherwise
  initial begin
    bus_activity = 1'b0;
    host_resume_seen = 1'b0;
    frame_start_seen = 1'b0;
    bus_reset_seen = 1'b0;
    bus_reset_done = 1'b0;
  end

  // Traffic level follows the bench, one edge late
  always @(posedge pclk) begin
    bus_activity <= alive;
  end

  // One-cycle host event, dropped at the next edge
  task automatic send(input int k);
    @(posedge pclk);
    case (k)
      0: frame_start_seen <= 1'b1;
      1: host_resume_seen <= 1'b1;
      2: bus_reset_seen <= 1'b1;
      default: bus_reset_done <= 1'b1;
    endcase
    @(posedge pclk);
    frame_start_seen <= 1'b0;
    host_resume_seen <= 1'b0;
    bus_reset_seen <= 1'b0;
    bus_reset_done <= 1'b0;
  endtask
endmodule

`default_nettype wire
